// file: include/sadc_consts.vh
`ifndef SADC_CONSTS_VH
`define SADC_CONSTS_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define SADC_OFF_CTRLA    8'h00
`define SADC_OFF_CTRLB    8'h04
`define SADC_OFF_CTRLC    8'h08
`define SADC_OFF_POSITIVE_INPUT_SELECT   8'h0C
`define SADC_OFF_COMMAND  8'h10
`define SADC_OFF_EVENT_CONTROL_REG   8'h14
`define SADC_OFF_INTERRUPT_FLAG_REG  8'h18
`define SADC_OFF_INTCLR   8'h1C
`define SADC_OFF_INTERRUPT_ENABLE_REG  8'h20
`define SADC_OFF_DEBUG_CONTROL_REG  8'h24
`define SADC_OFF_RES      8'h28

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SADC_BIT_ENABLE   0
`define SADC_BIT_RES8     2
`define SADC_ACC_MSB      2
`define SADC_CLOCK_DIVIDER_SELECT_MSB    2
`define SADC_REF_MSB      5
`define SADC_REF_LSB      4
`define SADC_MUX_MSB      4
`define SADC_BIT_GO       0
`define SADC_BIT_EVSTART  0
`define SADC_BIT_RESULT_READY_FLAG   0
`define SADC_BIT_RUN_IN_DEBUG   0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SADC_RST_REF      2'h0
`define SADC_RST_CLOCK_DIVIDER_SELECT    3'h0
`define SADC_RST_ACC      3'h0
`define SADC_RST_MUX      5'h00

// ----------------------------------------------------------------
// Conversion timing in conversion clock cycles, and eight bit mode result shift
// ----------------------------------------------------------------
`define SADC_CONV_CYCLES  13
`define SADC_SAMPLE_STEP  2
`define SADC_RES8_SHIFT   2

`endif

// file: verilog/sadc_prescaler.v
`timescale 1ns/1ns
`default_nettype none

// Conversion clock prescaler: divide by 2 << divider select
module sadc_prescaler #(
    parameter SEL_W = 3,
    parameter CNT_W = 8
) (
    // Clock and reset
    input  wire             clk_i,
    input  wire             rst_i,
    // Control
    input  wire             run_i,
    input  wire             hold_i,
    input  wire [SEL_W-1:0] sel_i,
    // Conversion clock rising edge
    output wire             tick_o
);

    reg  [CNT_W-1:0] cnt_reg;
    wire [CNT_W-1:0] last;

    // Terminal count is divisor minus one, shift widened for top select
    assign last   = ({{(CNT_W-1){1'b0}}, 1'b1}
                     << ({1'b0, sel_i} + {{SEL_W{1'b0}}, 1'b1})) - 1'b1;
    assign tick_o = run_i & ~hold_i & (cnt_reg == last);

    // Counter held at zero when idle, frozen when halted
    always @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            cnt_reg <= {CNT_W{1'b0}};
        end else if (!hold_i) begin
            if (cnt_reg == last) begin
                cnt_reg <= {CNT_W{1'b0}};
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// file: verilog/sadc_sar.v
`timescale 1ns/1ns
`include "sadc_consts.vh"
`default_nettype none

// Successive approximation engine, one bit per conversion clock
module sadc_sar #(
    parameter W = 10
) (
    // Clock and reset
    input  wire         clk_i,
    input  wire         rst_i,
    input  wire         abort_i,
    // Sequencing
    input  wire         tick_i,
    input  wire         start_i,
    input  wire         comp_i,
    // Analog side and result
    output reg          sample_o,
    output reg  [W-1:0] trial_o,
    output reg          done_o,
    output reg  [W-1:0] code_o,
    output reg          busy_o
);

    localparam integer LAST_N  = `SADC_CONV_CYCLES - 1;
    localparam integer SAMPL_N = `SADC_SAMPLE_STEP;
    localparam [3:0]   LAST    = LAST_N[3:0];
    localparam [3:0]   SAMPL   = SAMPL_N[3:0];

    reg  [3:0]   step_reg;
    wire [3:0]   bit_idx;
    wire [W-1:0] one_hot;
    wire [W-1:0] keep;
    wire         resolving;

    assign bit_idx   = LAST - step_reg;
    assign one_hot   = {{(W-1){1'b0}}, 1'b1} << bit_idx;
    assign resolving = busy_o & (step_reg > SAMPL);
    // Keep or drop the trial bit by comparator answer
    assign keep      = comp_i ? trial_o : (trial_o & ~one_hot);

    // Thirteen steps: sample at step two, then MSB to LSB
    always @(posedge clk_i) begin
        sample_o <= 1'b0;
        done_o   <= 1'b0;
        if (rst_i || abort_i) begin
            busy_o   <= 1'b0;
            step_reg <= 4'h0;
            trial_o  <= {W{1'b0}};
            code_o   <= {W{1'b0}};
        end else if (tick_i) begin
            if (!busy_o && start_i) begin
                busy_o   <= 1'b1;
                step_reg <= 4'h0;
                trial_o  <= {W{1'b0}};
            end else if (busy_o) begin
                step_reg <= step_reg + 1'b1;
                if (step_reg == SAMPL) begin
                    sample_o <= 1'b1;
                    trial_o  <= {1'b1, {(W-1){1'b0}}};
                end else if (resolving) begin
                    trial_o <= keep | (one_hot >> 1);
                end
                if (step_reg == LAST) begin
                    busy_o  <= 1'b0;
                    done_o  <= 1'b1;
                    code_o  <= keep;
                    trial_o <= {W{1'b0}};
                end
            end
        end
    end

endmodule
`default_nettype wire

// file: verilog/sadc_ctrl.v
// Operation
// - Conversion clock from own peripheral clock prescaler
// - Debug halt stops converter unless debug run
// - Debug run bit keeps converter going
// - Reference select resets to internal reference
// - Go bit starts conversion, reads one while busy
// - Hardware clears go bit on completion
// - Channel change waits for running conversion end
// - Result from one or accumulated samples, flag
// - Interrupt needs result enable and global enable
// - Result flag sets even with interrupt disabled
// - Event start enable lets events trigger conversion
// - Event edge sets go bit, cleared at end
// - Codes span zero to two power n minus one
// - Start on next conversion clock rising edge
// - Conversion lasts thirteen conversion clock cycles
// - Result read or write one clears flag
`timescale 1ns/1ns
`include "sadc_consts.vh"
`default_nettype none

module sadc_ctrl #(
    parameter CODE_W = 10,
    parameter ACC_W  = 16,
    parameter DIV_W  = 8
) (
    // Clock and reset
    input  wire              clk_i,
    input  wire              rst_i,
    // Wishbone slave
    input  wire              cyc_i,
    input  wire              stb_i,
    input  wire              we_i,
    input  wire [7:0]        adr_i,
    input  wire [3:0]        sel_i,
    input  wire [31:0]       dat_i,
    output reg  [31:0]       dat_o,
    output reg               ack_o,
    // System inputs
    input  wire              event_i,
    input  wire              debug_halt_i,
    input  wire              gie_i,
    // Analog front end
    input  wire              comp_i,
    output reg               adc_on_o,
    output reg  [4:0]        mux_sel_o,
    output reg  [1:0]        ref_sel_o,
    output wire              sample_o,
    output wire [CODE_W-1:0] dac_code_o,
    // Interrupt
    output wire              irq_o
);

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_WAIT = 2'h1;
    localparam [1:0] ST_CONV = 2'h2;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    reg              enable_reg;
    reg              res8_reg;
    reg  [2:0]       acc_sel_reg;
    reg  [2:0]       clock_divider_select_reg;
    reg  [1:0]       ref_reg;
    reg  [4:0]       mux_reg;
    reg              go_reg;
    reg              go_next;
    reg              ev_start_reg;
    reg              flag_reg;
    reg              flag_next;
    reg              irq_en_reg;
    reg              dbg_run_reg;
    reg  [ACC_W-1:0] res_reg;
    reg  [ACC_W-1:0] acc_reg;
    reg  [6:0]       cnt_reg;
    reg  [1:0]       state_reg;
    reg  [1:0]       state_next;
    reg              event_d_reg;
    reg  [31:0]      rd_data;

    wire             bus_req;
    wire             wr_en;
    wire             rd_en;
    wire             halt;
    wire             tick;
    wire             sar_start;
    wire             sar_done;
    wire             sar_busy;
    wire [CODE_W-1:0] sar_code;
    wire [CODE_W-1:0] code_adj;
    wire [ACC_W-1:0] acc_sum;
    wire [6:0]       cnt_last;
    wire             last_sample;
    wire             finish;
    wire             ev_edge;
    wire             go_wr;
    wire             clr_wr;
    wire             res_rd;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // One request per strobe, answered one cycle later
    assign bus_req = cyc_i & stb_i & ~ack_o;
    assign wr_en   = bus_req & we_i & sel_i[0];
    assign rd_en   = bus_req & ~we_i;

    // Go write honoured only while enabled
    assign go_wr  = wr_en & (adr_i == `SADC_OFF_COMMAND)
                  & dat_i[`SADC_BIT_GO] & enable_reg;
    assign clr_wr = wr_en & (adr_i == `SADC_OFF_INTCLR)
                  & dat_i[`SADC_BIT_RESULT_READY_FLAG];
    assign res_rd = rd_en & (adr_i == `SADC_OFF_RES);

    // ------------------------------------------------------------
    // Debug halt and event edge
    // ------------------------------------------------------------
    assign halt    = debug_halt_i & ~dbg_run_reg;
    // Rising edge of the routed event, only when enabled
    assign ev_edge = event_i & ~event_d_reg & ev_start_reg
                   & enable_reg & ~halt;

    // ------------------------------------------------------------
    // Conversion clock and SAR engine
    // ------------------------------------------------------------
    // Prescaler runs only while a conversion is pending
    sadc_prescaler #(
        .SEL_W (3),
        .CNT_W (DIV_W)
    ) u_clock_divider_select (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .run_i  (enable_reg & go_reg),
        .hold_i (halt),
        .sel_i  (clock_divider_select_reg),
        .tick_o (tick)
    );

    assign sar_start = (state_reg == ST_WAIT);

    sadc_sar #(
        .W (CODE_W)
    ) u_sar (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .abort_i  (~enable_reg),
        .tick_i   (tick),
        .start_i  (sar_start),
        .comp_i   (comp_i),
        .sample_o (sample_o),
        .trial_o  (dac_code_o),
        .done_o   (sar_done),
        .code_o   (sar_code),
        .busy_o   (sar_busy)
    );

    // ------------------------------------------------------------
    // Accumulation
    // ------------------------------------------------------------
    // Eight bit mode keeps the upper code bits, max 0xFF
    assign code_adj = res8_reg ? (sar_code >> `SADC_RES8_SHIFT)
                               : sar_code;
    assign acc_sum  = acc_reg + {{(ACC_W-CODE_W){1'b0}}, code_adj};
    assign cnt_last = (7'h01 << acc_sel_reg) - 7'h01;
    assign last_sample = (cnt_reg == cnt_last);
    assign finish   = (state_reg == ST_CONV) & sar_done
                    & last_sample;

    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (go_reg) begin
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (tick) begin
                    state_next = ST_CONV;
                end
            end
            ST_CONV: begin
                if (sar_done) begin
                    state_next = last_sample ? ST_IDLE : ST_WAIT;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        if (!enable_reg) begin
            state_next = ST_IDLE;
        end
    end

    // ------------------------------------------------------------
    // Go bit and result flag next values
    // ------------------------------------------------------------
    always @* begin
        go_next = go_reg;
        if (finish || !enable_reg) begin
            go_next = 1'b0;
        end
        if (go_wr || ev_edge) begin
            go_next = enable_reg;
        end
        flag_next = flag_reg;
        if (clr_wr || res_rd) begin
            flag_next = 1'b0;
        end
        if (finish) begin
            flag_next = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Sequencer, accumulator and result
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_reg   <= ST_IDLE;
            go_reg      <= 1'b0;
            flag_reg    <= 1'b0;
            acc_reg     <= {ACC_W{1'b0}};
            cnt_reg     <= 7'h00;
            res_reg     <= {ACC_W{1'b0}};
            event_d_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            go_reg      <= go_next;
            flag_reg    <= flag_next;
            event_d_reg <= event_i;
            if (state_reg == ST_IDLE) begin
                acc_reg <= {ACC_W{1'b0}};
                cnt_reg <= 7'h00;
            end else if (sar_done) begin
                if (last_sample) begin
                    res_reg <= acc_sum;
                    acc_reg <= {ACC_W{1'b0}};
                    cnt_reg <= 7'h00;
                end else begin
                    acc_reg <= acc_sum;
                    cnt_reg <= cnt_reg + 7'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Analog selections
    // ------------------------------------------------------------
    // Channel and reference locked while a conversion is pending
    always @(posedge clk_i) begin
        if (rst_i) begin
            mux_sel_o <= `SADC_RST_MUX;
            ref_sel_o <= `SADC_RST_REF;
            adc_on_o  <= 1'b0;
        end else begin
            adc_on_o <= enable_reg;
            if (!go_reg && enable_reg) begin
                mux_sel_o <= mux_reg;
                ref_sel_o <= ref_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            enable_reg   <= 1'b0;
            res8_reg     <= 1'b0;
            acc_sel_reg  <= `SADC_RST_ACC;
            clock_divider_select_reg    <= `SADC_RST_CLOCK_DIVIDER_SELECT;
            ref_reg      <= `SADC_RST_REF;
            mux_reg      <= `SADC_RST_MUX;
            ev_start_reg <= 1'b0;
            irq_en_reg   <= 1'b0;
            dbg_run_reg  <= 1'b0;
        end else if (wr_en) begin
            if (adr_i == `SADC_OFF_CTRLA) begin
                enable_reg <= dat_i[`SADC_BIT_ENABLE];
                res8_reg   <= dat_i[`SADC_BIT_RES8];
            end else if (adr_i == `SADC_OFF_CTRLB) begin
                acc_sel_reg <= (dat_i[`SADC_ACC_MSB:0] > 3'h6)
                             ? 3'h6 : dat_i[`SADC_ACC_MSB:0];
            end else if (adr_i == `SADC_OFF_CTRLC) begin
                clock_divider_select_reg <= dat_i[`SADC_CLOCK_DIVIDER_SELECT_MSB:0];
                ref_reg   <= dat_i[`SADC_REF_MSB:`SADC_REF_LSB];
            end else if (adr_i == `SADC_OFF_POSITIVE_INPUT_SELECT) begin
                mux_reg <= dat_i[`SADC_MUX_MSB:0];
            end else if (adr_i == `SADC_OFF_EVENT_CONTROL_REG) begin
                ev_start_reg <= dat_i[`SADC_BIT_EVSTART];
            end else if (adr_i == `SADC_OFF_INTERRUPT_ENABLE_REG) begin
                irq_en_reg <= dat_i[`SADC_BIT_RESULT_READY_FLAG];
            end else if (adr_i == `SADC_OFF_DEBUG_CONTROL_REG) begin
                dbg_run_reg <= dat_i[`SADC_BIT_RUN_IN_DEBUG];
            end
        end
    end

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    always @* begin
        rd_data = 32'h0000_0000;
        if (adr_i == `SADC_OFF_CTRLA) begin
            rd_data[`SADC_BIT_ENABLE] = enable_reg;
            rd_data[`SADC_BIT_RES8]   = res8_reg;
        end else if (adr_i == `SADC_OFF_CTRLB) begin
            rd_data[`SADC_ACC_MSB:0] = acc_sel_reg;
        end else if (adr_i == `SADC_OFF_CTRLC) begin
            rd_data[`SADC_CLOCK_DIVIDER_SELECT_MSB:0] = clock_divider_select_reg;
            rd_data[`SADC_REF_MSB:`SADC_REF_LSB] = ref_reg;
        end else if (adr_i == `SADC_OFF_POSITIVE_INPUT_SELECT) begin
            rd_data[`SADC_MUX_MSB:0] = mux_reg;
        end else if (adr_i == `SADC_OFF_COMMAND) begin
            rd_data[`SADC_BIT_GO] = go_reg;
        end else if (adr_i == `SADC_OFF_EVENT_CONTROL_REG) begin
            rd_data[`SADC_BIT_EVSTART] = ev_start_reg;
        end else if (adr_i == `SADC_OFF_INTERRUPT_FLAG_REG) begin
            rd_data[`SADC_BIT_RESULT_READY_FLAG] = flag_reg;
        end else if (adr_i == `SADC_OFF_INTERRUPT_ENABLE_REG) begin
            rd_data[`SADC_BIT_RESULT_READY_FLAG] = irq_en_reg;
        end else if (adr_i == `SADC_OFF_DEBUG_CONTROL_REG) begin
            rd_data[`SADC_BIT_RUN_IN_DEBUG] = dbg_run_reg;
        end else if (adr_i == `SADC_OFF_RES) begin
            rd_data[ACC_W-1:0] = res_reg;
        end
    end

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    // Every address acknowledged, unmapped reads give zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= bus_req;
            if (rd_en) begin
                dat_o <= rd_data;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt output
    // ------------------------------------------------------------
    assign irq_o = flag_reg & irq_en_reg & gie_i;

endmodule
`default_nettype wire

// file: tb/sadc_ctrl_monitor.sv
`timescale 1ns/1ns
`include "sadc_consts.vh"
`default_nettype none
// ----
// Port checker
// ----
module sadc_ctrl_monitor (
    // Clock, reset and bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic        ack_o,
    // System and front end
    input wire logic        debug_halt_i,
    input wire logic        gie_i,
    input wire logic        adc_on_o,
    input wire logic [4:0]  mux_sel_o,
    input wire logic [1:0]  ref_sel_o,
    input wire logic        sample_o,
    input wire logic [9:0]  dac_code_o,
    input wire logic        irq_o
);
    logic ien_reg;
    logic dbg_run_reg;
    wire  take = cyc_i & stb_i & ~ack_o;
    wire  wr0  = take & we_i & sel_i[0];
    // Shadows of interrupt enable and debug run
    always @(posedge clk_i) begin
        if (rst_i) begin
            ien_reg     <= 1'b0;
            dbg_run_reg <= 1'b0;
        end else begin
            if (wr0 && adr_i == `SADC_OFF_INTERRUPT_ENABLE_REG) ien_reg <= dat_i[0];
            if (wr0 && adr_i == `SADC_OFF_DEBUG_CONTROL_REG) dbg_run_reg <= dat_i[0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_sampled; sample_o; endsequence
    sequence s_frozen; debug_halt_i && !dbg_run_reg; endsequence
    a_ack_one_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_ack_answers: assert property (take |=> ack_o)
        else $error("bus request not acknowledged");
    a_irq_both_enables: assert property (irq_o |-> gie_i && ien_reg)
        else $error("interrupt without both enables");
    a_ref_reset: assert property (disable iff (1'b0) rst_i |=> ref_sel_o == 2'h0)
        else $error("reference not internal after reset");
    a_channel_held: assert property (s_sampled |=> ($stable(mux_sel_o) && $stable(ref_sel_o))[*8])
        else $error("channel changed during conversion");
    a_halt_freezes: assert property (s_frozen |=> $stable(dac_code_o) && !sample_o)
        else $error("converter ran while halted");
    a_idle_no_sample: assert property (!adc_on_o ##1 !adc_on_o |-> !sample_o)
        else $error("sample while disabled");
    a_clear_drops_irq: assert property (wr0 && adr_i == `SADC_OFF_INTCLR && dat_i[0] |=> !irq_o)
        else $error("flag clear write left interrupt up");
    a_read_drops_irq: assert property (take && !we_i && adr_i == `SADC_OFF_RES |-> ##2 !irq_o)
        else $error("result read left interrupt up");
endmodule

bind sadc_ctrl sadc_ctrl_monitor u_monitor (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o),
    .debug_halt_i(debug_halt_i), .gie_i(gie_i), .adc_on_o(adc_on_o), .mux_sel_o(mux_sel_o),
    .ref_sel_o(ref_sel_o), .sample_o(sample_o), .dac_code_o(dac_code_o), .irq_o(irq_o));
`default_nettype wire

// file: tb/sadc_front_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// Analog inputs and comparator
// ----
module sadc_front_model (
    // Clock
    input wire logic       clk_i,
    // From converter
    input wire logic       adc_on_i,
    input wire logic [4:0] mux_sel_i,
    input wire logic [9:0] dac_code_i,
    // Comparator answer
    output logic           comp_o
);
    logic       noise_reg = 1'b0;
    wire  [9:0] level = 10'(mux_sel_i) * 10'd33; // Channel n holds 33 * n, top 0x3FF
    // Powered down comparator gives no steady answer
    always @(posedge clk_i) noise_reg <= ~noise_reg;
    assign comp_o = adc_on_i ? (level >= dac_code_i) : noise_reg;
endmodule
`default_nettype wire

// file: tb/sadc_ctrl_bench.sv
`timescale 1ns/1ns
`include "sadc_consts.vh"
`default_nettype none
// ----
// Bench for the conversion control
// ----
module sadc_ctrl_bench;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic        event_i = 0, debug_halt_i = 0, gie_i = 0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, rd;
    wire  [31:0] dat_o;
    wire         ack_o, comp_i, adc_on_o, sample_o, irq_o;
    wire  [4:0]  mux_sel_o;
    wire  [1:0]  ref_sel_o;
    wire  [9:0]  dac_code_o;
    int          n_errors = 0, samples_checked = 0, cycles = 0, t0, t1, i;
    logic [31:0] cfg [4][4] = '{'{1, 0, 0, 0}, '{5, 0, 31, 'hFF}, '{1, 2, 10, 'h528},
                               '{1, 7, 31, 'hFFC0}};
    sadc_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .event_i(event_i), .debug_halt_i(debug_halt_i), .gie_i(gie_i), .comp_i(comp_i),
        .adc_on_o(adc_on_o), .mux_sel_o(mux_sel_o), .ref_sel_o(ref_sel_o),
        .sample_o(sample_o), .dac_code_o(dac_code_o), .irq_o(irq_o));
    sadc_front_model front (.clk_i(clk_i), .adc_on_i(adc_on_o), .mux_sel_i(mux_sel_o),
        .dac_code_i(dac_code_o), .comp_o(comp_i));
    // Clock and hang guard
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_errors++;
            conclude();
        end
    end
    task conclude();
        if (n_errors == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One classic bus cycle, read data left in rd
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        cyc_i <= 1;
        stb_i <= 1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        n = 0;
        @(posedge clk_i);
        while (ack_o !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 50) check("ack", 1, 0);
        rd = dat_o;
        cyc_i <= 0;
        stb_i <= 0;
        we_i <= 0;
        @(posedge clk_i);
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] exp, input string name);
        wb(0, a, 0);
        check(name, exp, rd);
    endtask
    // Poll the go bit until the conversion ends
    task wait_idle();
        int n;
        n = 0;
        do begin
            wb(0, `SADC_OFF_COMMAND, 0);
            n++;
        end while (rd[0] === 1'b1 && n < 2000);
        check("go_idle", 0, rd);
    endtask
    task conv_time(output int c);
        wb(1, `SADC_OFF_COMMAND, 1);
        c = 0;
        while (irq_o !== 1'b1 && c < 5000) begin
            @(posedge clk_i);
            c++;
        end
    endtask
    // Main sequence
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        check("ref_sel", 0, ref_sel_o);
        rdc(`SADC_OFF_INTERRUPT_FLAG_REG, 0, "flag");
        rdc(8'h3C, 0, "unmapped");
        wb(1, `SADC_OFF_EVENT_CONTROL_REG, 1);
        wb(1, `SADC_OFF_COMMAND, 1);
        event_i <= 1;
        repeat (3) @(posedge clk_i);
        event_i <= 0;
        rdc(`SADC_OFF_COMMAND, 0, "go_off");
        wb(1, `SADC_OFF_EVENT_CONTROL_REG, 0);
        wb(1, `SADC_OFF_CTRLC, 32'h20);
        wb(1, `SADC_OFF_POSITIVE_INPUT_SELECT, 31);
        wb(1, `SADC_OFF_INTERRUPT_ENABLE_REG, 1);
        wb(1, `SADC_OFF_CTRLA, 1);
        check("ref_sel_on", 2, ref_sel_o);
        wb(1, `SADC_OFF_COMMAND, 1);
        rdc(`SADC_OFF_COMMAND, 1, "go_busy");
        wait_idle();
        rdc(`SADC_OFF_INTERRUPT_FLAG_REG, 1, "flag_poll");
        check("irq_no_gie", 0, irq_o);
        gie_i <= 1;
        @(posedge clk_i);
        check("irq_gie", 1, irq_o);
        rdc(`SADC_OFF_RES, 'h3FF, "res_top");
        rdc(`SADC_OFF_INTERRUPT_FLAG_REG, 0, "flag_read");
        conv_time(t0);
        wb(0, `SADC_OFF_RES, 0);
        wb(1, `SADC_OFF_CTRLC, 32'h21);
        conv_time(t1);
        check("delta", 28, t1 - t0);
        wb(1, `SADC_OFF_INTCLR, 1);
        rdc(`SADC_OFF_INTERRUPT_FLAG_REG, 0, "flag_clr");
        wb(1, `SADC_OFF_CTRLC, 32'h20);
        for (i = 0; i < 4; i++) begin
            wb(1, `SADC_OFF_CTRLA, cfg[i][0]);
            wb(1, `SADC_OFF_CTRLB, cfg[i][1]);
            wb(1, `SADC_OFF_POSITIVE_INPUT_SELECT, cfg[i][2]);
            wb(1, `SADC_OFF_COMMAND, 1);
            wait_idle();
            rdc(`SADC_OFF_RES, cfg[i][3], "res_mode");
        end
        wb(1, `SADC_OFF_CTRLA, 1);
        wb(1, `SADC_OFF_CTRLB, 0);
        wb(1, `SADC_OFF_COMMAND, 1);
        wb(1, `SADC_OFF_POSITIVE_INPUT_SELECT, 10);
        check("mux_busy", 31, mux_sel_o);
        wait_idle();
        rdc(`SADC_OFF_RES, 'h3FF, "res_old_ch");
        check("mux_after", 10, mux_sel_o);
        wb(1, `SADC_OFF_EVENT_CONTROL_REG, 1);
        event_i <= 1;
        repeat (2) @(posedge clk_i);
        rdc(`SADC_OFF_COMMAND, 1, "go_event");
        wait_idle();
        rdc(`SADC_OFF_RES, 'h14A, "res_event");
        repeat (40) @(posedge clk_i);
        rdc(`SADC_OFF_COMMAND, 0, "go_level");
        event_i <= 0;
        wb(1, `SADC_OFF_EVENT_CONTROL_REG, 0);
        wb(1, `SADC_OFF_POSITIVE_INPUT_SELECT, 20);
        wb(1, `SADC_OFF_COMMAND, 1);
        debug_halt_i <= 1;
        repeat (200) @(posedge clk_i);
        rdc(`SADC_OFF_COMMAND, 1, "go_halt");
        check("irq_halt", 0, irq_o);
        debug_halt_i <= 0;
        wait_idle();
        rdc(`SADC_OFF_RES, 'h294, "res_halt");
        wb(1, `SADC_OFF_DEBUG_CONTROL_REG, 1);
        wb(1, `SADC_OFF_POSITIVE_INPUT_SELECT, 3);
        debug_halt_i <= 1;
        wb(1, `SADC_OFF_COMMAND, 1);
        wait_idle();
        rdc(`SADC_OFF_RES, 'h63, "res_run_in_debug");
        debug_halt_i <= 0;
        wb(1, `SADC_OFF_COMMAND, 1);
        wb(1, `SADC_OFF_CTRLA, 0);
        rdc(`SADC_OFF_COMMAND, 0, "go_abort");
        rdc(`SADC_OFF_INTERRUPT_FLAG_REG, 0, "flag_abort");
        conclude();
    end
endmodule
`default_nettype wire
